// ==== shared/spat_map.vh ====
// Purpose: offsets, field positions, reset values and codes of the address translator
// Assumes: included by its bare name; definitions only
// Notes:   all registers are one aligned 32-bit word on the AHB-Lite slave
`ifndef SPAT_MAP_VH
`define SPAT_MAP_VH

// register byte offsets
`define SPAT_OFS_CTRL        8'h00
`define SPAT_OFS_FLAGS       8'h04
`define SPAT_OFS_DIR_BASE    8'h08
`define SPAT_OFS_FAULT_ADDR  8'h0C
`define SPAT_OFS_GLOBAL_BASE 8'h10
`define SPAT_OFS_LOCAL_BASE  8'h14
`define SPAT_OFS_STATUS      8'h18

// control fields
`define SPAT_CTRL_PROT_BIT   0
`define SPAT_CTRL_PAGE_BIT   1
// flags fields
`define SPAT_FLAGS_EMUL_BIT  0
`define SPAT_FLAGS_SAVED_BIT 1
// status fields
`define SPAT_STAT_BUSY_BIT   3

// reset values
`define SPAT_RST_CTRL        2'h0
`define SPAT_RST_WORD        32'h0000_0000

// table entry fields
`define SPAT_PRESENT_BIT     0

// fault codes
`define SPAT_FLT_NONE        3'h0
`define SPAT_FLT_WRAP        3'h1
`define SPAT_FLT_SENSITIVE   3'h2
`define SPAT_FLT_PAGE_DIR    3'h3
`define SPAT_FLT_PAGE_TBL    3'h4
`define SPAT_FLT_SEG_ABSENT  3'h5

// real-mode segment limit and per-table entry span
`define SPAT_SEG_LAST_OFS    17'h0_FFFF
`define SPAT_DESC_BYTES      8

`endif

// ==== rtl/spat_translator.v ====
// Purpose: segment and page address translator with AHB-Lite control registers
// Assumes: one clock ref_clk at 100 MHz; rst_b synchronous active low; table memory on same clock
// Notes:   one request at a time; a segment load has priority over a translation
//
// Behaviour
// - real mode: segment value becomes bits 19:4 of a 20-bit base, low nibble zero
// - real mode segments span 64KB with read, write and execute, no protection check
// - real mode access wrapping offset FFFF to 0000 raises a fault instead
// - protected mode accepts 16-bit selector with 16-bit or 32-bit offset
// - selector indexes global or local descriptor table, entry gives 32-bit base
// - linear address is 32-bit effective offset plus descriptor base
// - loading a segment register fetches its 8-byte descriptor automatically
// - protected mode covers 4GB physical and 64TB virtual space per task
// - paging applies only in protected mode, after segmentation
// - with paging off the linear address is the physical address
// - emulation mode linear addresses stay in the first 1MB; paging may relocate
// - emulation or native behaviour follows the emulation flag in the flags register
// - emulation mode raises a fault on I/O, interrupt or other sensitive instructions
// - any exception or interrupt leaves emulation mode; saved image keeps the flag
// - fault address register holds linear address of the latest page fault
// - page directory start address comes from the directory base register
// - linear bits 31:22 select one of 1024 page directory entries
// - linear bits 21:12 select one of 1024 page table entries
// - physical address is 20 frame bits above 12 low linear bits
//
// Design decisions made here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ns
`include "spat_map.vh"

module spat_translator (
  input  wire        ref_clk,
  input  wire        rst_b,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  // segment register load from the core
  input  wire        seg_load,
  input  wire [1:0]  seg_load_idx,
  input  wire [15:0] seg_load_sel,
  output reg         seg_load_done,
  // translation request from the core
  input  wire        xlat_valid,
  output wire        xlat_ready,
  input  wire [1:0]  xlat_seg,
  input  wire [31:0] xlat_offset,
  input  wire        xlat_op32,
  input  wire [1:0]  xlat_len,
  input  wire        xlat_sensitive,
  output reg         xlat_done,
  output reg  [31:0] phys_addr,
  output reg         fault_valid,
  output reg  [2:0]  fault_code,
  // external interrupt entry
  input  wire        intr_entry,
  output wire        emul_mode,
  // descriptor and page table memory
  output reg         mem_req,
  output reg  [31:0] mem_addr,
  input  wire        mem_ack,
  input  wire [31:0] mem_rdata
);

  localparam ST_IDLE  = 3'h0;
  localparam ST_DESC0 = 3'h1;
  localparam ST_DESC1 = 3'h2;
  localparam ST_PDE   = 3'h3;
  localparam ST_PTE   = 3'h4;

  //////////////////////////////////////////////////////////////////////////////
  // table memory master port
  //////////////////////////////////////////////////////////////////////////////
  // acknowledge counts only while our own request stands
  wire        mem_ack_w;

  //////////////////////////////////////////////////////////////////////////////
  // state
  //////////////////////////////////////////////////////////////////////////////
  reg  [2:0]  state;
  reg  [1:0]  ctrl;
  reg         emul_flag;
  reg         saved_emul;
  reg  [31:0] directory_base_reg;
  reg  [31:0] fault_linear_addr_reg;
  reg  [31:0] global_table_base;
  reg  [31:0] local_table_base;
  reg  [15:0] seg_sel  [0:3];
  reg  [31:0] seg_base [0:3];
  reg  [1:0]  load_idx;
  reg  [31:0] desc_base;
  reg  [31:0] lin_addr;
  reg         dp_wr;
  reg  [7:0]  dp_addr;

  wire prot_en   = ctrl[`SPAT_CTRL_PROT_BIT];
  wire paging_en = ctrl[`SPAT_CTRL_PAGE_BIT] & prot_en;
  wire emul_on   = prot_en & emul_flag;

  assign emul_mode  = emul_on;
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign xlat_ready = (state == ST_IDLE) & ~seg_load;

  //////////////////////////////////////////////////////////////////////////////
  // address formation
  //////////////////////////////////////////////////////////////////////////////
  wire [15:0] cur_sel   = seg_sel[xlat_seg];
  wire [19:0] rm_base   = {cur_sel, 4'h0};
  wire [19:0] rm_sum    = rm_base + {4'h0, xlat_offset[15:0]};
  wire [16:0] last_byte = {1'b0, xlat_offset[15:0]} + {15'h0, xlat_len};
  wire        wraps     = last_byte > `SPAT_SEG_LAST_OFS;
  wire [31:0] eff_ofs   = xlat_op32 ? xlat_offset : {16'h0, xlat_offset[15:0]};
  wire [31:0] pm_lin    = seg_base[xlat_seg] + eff_ofs;
  // emulated tasks use 20-bit formation, confined to the first 1MB
  wire [31:0] rm_lin    = {12'h000, rm_sum};
  wire [31:0] new_lin   = (prot_en & ~emul_on) ? pm_lin : rm_lin;

  // descriptor address: table chosen by selector bit 2, index times eight
  wire [31:0] tbl_base  = seg_load_sel[2] ? local_table_base : global_table_base;
  wire [31:0] desc_addr = tbl_base + {16'h0, seg_load_sel[15:3], 3'h0};

  wire        accept_load = (state == ST_IDLE) & seg_load;
  wire        accept_xlat = (state == ST_IDLE) & ~seg_load & xlat_valid;
  // fault entry conditions, checked when a request is taken or a table read is acknowledged
  wire        sens_fault  = emul_on & xlat_sensitive;
  wire        wrap_fault  = (~prot_en | emul_on) & wraps;
  wire        entry_fault = accept_xlat & (sens_fault | wrap_fault);
  wire        walk_fault  = mem_ack_w & ~mem_rdata[`SPAT_PRESENT_BIT] & ((state == ST_PDE) | (state == ST_PTE));
  wire        desc_fault  = mem_ack_w & (state == ST_DESC1) & ~mem_rdata[`SPAT_PRESENT_BIT];
  wire        exc_entry   = entry_fault | walk_fault | desc_fault | intr_entry;

  //////////////////////////////////////////////////////////////////////////////
  // translation and descriptor fetch sequencer
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      state                 <= ST_IDLE;
      mem_req               <= 1'b0;
      mem_addr              <= `SPAT_RST_WORD;
      load_idx              <= 2'h0;
      desc_base             <= `SPAT_RST_WORD;
      lin_addr              <= `SPAT_RST_WORD;
      phys_addr             <= `SPAT_RST_WORD;
      xlat_done             <= 1'b0;
      seg_load_done         <= 1'b0;
      fault_valid           <= 1'b0;
      fault_code            <= `SPAT_FLT_NONE;
      fault_linear_addr_reg <= `SPAT_RST_WORD;
    end else begin
      xlat_done     <= 1'b0;
      seg_load_done <= 1'b0;
      fault_valid   <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (accept_load) begin
            load_idx <= seg_load_idx;
            if (prot_en & ~emul_on) begin
              mem_req  <= 1'b1;
              mem_addr <= desc_addr;
              state    <= ST_DESC0;
            end else begin
              seg_load_done <= 1'b1;
            end
          end else if (accept_xlat) begin
            lin_addr <= new_lin;
            if (emul_on & xlat_sensitive) begin
              fault_valid <= 1'b1;
              fault_code  <= `SPAT_FLT_SENSITIVE;
            end else if ((~prot_en | emul_on) & wraps) begin
              fault_valid <= 1'b1;
              fault_code  <= `SPAT_FLT_WRAP;
            end else if (paging_en) begin
              mem_req  <= 1'b1;
              mem_addr <= {directory_base_reg[31:12], new_lin[31:22], 2'h0};
              state    <= ST_PDE;
            end else begin
              // real mode has no protection check: 64KB, any access type
              phys_addr <= new_lin;
              xlat_done <= 1'b1;
            end
          end
        end
        ST_DESC0: begin
          if (mem_ack_w) begin
            desc_base <= mem_rdata;
            mem_addr  <= mem_addr + 32'h0000_0004;
            state     <= ST_DESC1;
          end
        end
        ST_DESC1: begin
          if (mem_ack_w) begin
            mem_req <= 1'b0;
            state   <= ST_IDLE;
            if (mem_rdata[`SPAT_PRESENT_BIT]) begin
              seg_load_done <= 1'b1;
            end else begin
              fault_valid <= 1'b1;
              fault_code  <= `SPAT_FLT_SEG_ABSENT;
            end
          end
        end
        ST_PDE: begin
          if (mem_ack_w) begin
            if (mem_rdata[`SPAT_PRESENT_BIT]) begin
              mem_addr <= {mem_rdata[31:12], lin_addr[21:12], 2'h0};
              state    <= ST_PTE;
            end else begin
              mem_req               <= 1'b0;
              state                 <= ST_IDLE;
              fault_valid           <= 1'b1;
              fault_code            <= `SPAT_FLT_PAGE_DIR;
              fault_linear_addr_reg <= lin_addr;
            end
          end
        end
        ST_PTE: begin
          if (mem_ack_w) begin
            mem_req <= 1'b0;
            state   <= ST_IDLE;
            if (mem_rdata[`SPAT_PRESENT_BIT]) begin
              phys_addr <= {mem_rdata[31:12], lin_addr[11:0]};
              xlat_done <= 1'b1;
            end else begin
              fault_valid           <= 1'b1;
              fault_code            <= `SPAT_FLT_PAGE_TBL;
              fault_linear_addr_reg <= lin_addr;
            end
          end
        end
        default: begin
          mem_req <= 1'b0;
          state   <= ST_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // segment register file
  //////////////////////////////////////////////////////////////////////////////
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_seg
      always @(posedge ref_clk) begin
        if (!rst_b) begin
          seg_sel[gi]  <= 16'h0000;
          seg_base[gi] <= `SPAT_RST_WORD;
        end else if (accept_load & (seg_load_idx == gi) & ~(prot_en & ~emul_on)) begin
          seg_sel[gi]  <= seg_load_sel;
          seg_base[gi] <= {12'h000, seg_load_sel, 4'h0};
        end else if (accept_load & (seg_load_idx == gi)) begin
          seg_sel[gi]  <= seg_load_sel;
        end else if ((state == ST_DESC1) & mem_ack_w & mem_rdata[`SPAT_PRESENT_BIT] & (load_idx == gi)) begin
          seg_base[gi] <= desc_base;
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // AHB-Lite register slave
  //////////////////////////////////////////////////////////////////////////////
  wire ap_valid = hsel & htrans[1] & hready;
  reg  [31:0] rd_mux;
  // status: busy flag above the last fault code
  wire busy = (state != ST_IDLE);

  always @* begin
    case (haddr[7:0])
      `SPAT_OFS_CTRL: begin
        rd_mux = {30'h0, ctrl};
      end
      `SPAT_OFS_FLAGS: begin
        rd_mux = {30'h0, saved_emul, emul_flag};
      end
      `SPAT_OFS_DIR_BASE: begin
        rd_mux = directory_base_reg;
      end
      `SPAT_OFS_FAULT_ADDR: begin
        rd_mux = fault_linear_addr_reg;
      end
      `SPAT_OFS_GLOBAL_BASE: begin
        rd_mux = global_table_base;
      end
      `SPAT_OFS_LOCAL_BASE: begin
        rd_mux = local_table_base;
      end
      `SPAT_OFS_STATUS: begin
        rd_mux = {28'h0, busy, fault_code};
      end
      default: begin
        rd_mux = `SPAT_RST_WORD;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (!rst_b) begin
      dp_wr   <= 1'b0;
      dp_addr <= 8'h00;
      hrdata  <= `SPAT_RST_WORD;
    end else begin
      dp_wr <= ap_valid & hwrite;
      if (ap_valid) begin
        dp_addr <= haddr[7:0];
      end
      if (ap_valid & ~hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_b) begin
      ctrl               <= `SPAT_RST_CTRL;
      directory_base_reg <= `SPAT_RST_WORD;
      global_table_base  <= `SPAT_RST_WORD;
      local_table_base   <= `SPAT_RST_WORD;
    end else if (dp_wr) begin
      case (dp_addr)
        `SPAT_OFS_CTRL: begin
          ctrl <= hwdata[1:0];
        end
        `SPAT_OFS_DIR_BASE: begin
          directory_base_reg <= hwdata;
        end
        `SPAT_OFS_GLOBAL_BASE: begin
          global_table_base <= hwdata;
        end
        `SPAT_OFS_LOCAL_BASE: begin
          local_table_base <= hwdata;
        end
        default: begin
          ctrl <= ctrl;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // emulation flag and exception entry
  //////////////////////////////////////////////////////////////////////////////
  // an exception entry beats a software write in the same cycle
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      emul_flag  <= 1'b0;
      saved_emul <= 1'b0;
    end else if (exc_entry) begin
      saved_emul <= emul_flag;
      emul_flag  <= 1'b0;
    end else if (dp_wr & (dp_addr == `SPAT_OFS_FLAGS)) begin
      emul_flag  <= hwdata[`SPAT_FLAGS_EMUL_BIT];
      saved_emul <= hwdata[`SPAT_FLAGS_SAVED_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // table memory port wiring
  //////////////////////////////////////////////////////////////////////////////
  assign mem_ack_w  = mem_ack & mem_req;

endmodule

// ==== testbench/spat_translator_assertions.sv ====
// Purpose: port assertions of the segment and page address translator
// Assumes: bound to spat_translator, one clock domain
// Notes:   answer bounds are loose; exact data is checked by the bench
`timescale 1ns/1ns
module spat_checker (
  input wire       ref_clk,
  input wire       rst_b,
  input wire       hreadyout,
  input wire       hresp,
  input wire       seg_load,
  input wire       seg_load_done,
  input wire       xlat_valid,
  input wire       xlat_ready,
  input wire       xlat_sensitive,
  input wire       xlat_done,
  input wire       fault_valid,
  input wire [2:0] fault_code,
  input wire       intr_entry,
  input wire       emul_mode
);
  sequence s_taken;
    xlat_valid && xlat_ready;
  endsequence
  sequence s_answer;
    xlat_done || fault_valid;
  endsequence
  a_answer_bound: assert property (@(posedge ref_clk) disable iff (!rst_b) s_taken |-> ##[1:300] s_answer)
    else $error("translation request not answered");
  a_sens_fault: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_taken ##0 (emul_mode && xlat_sensitive) |=> fault_valid && fault_code == 3'h2)
    else $error("sensitive access in emulation gave no fault");
  a_intr_exit: assert property (@(posedge ref_clk) disable iff (!rst_b) intr_entry |=> !emul_mode)
    else $error("emulation kept after interrupt entry");
  a_fault_exit: assert property (@(posedge ref_clk) disable iff (!rst_b) fault_valid |=> !emul_mode)
    else $error("emulation kept after fault");
  a_ready_block: assert property (@(posedge ref_clk) disable iff (!rst_b) seg_load |-> !xlat_ready)
    else $error("translation ready during segment load");
  a_answer_excl: assert property (@(posedge ref_clk) disable iff (!rst_b) !(xlat_done && fault_valid))
    else $error("done and fault together");
  a_seg_answer: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(seg_load) |-> ##[1:300] seg_load_done)
    else $error("segment load not completed");
  a_reset_quiet: assert property (@(posedge ref_clk) !rst_b |=> !xlat_done && !fault_valid
    && !seg_load_done && !emul_mode && hreadyout && !hresp)
    else $error("outputs active after reset");
endmodule

bind spat_translator spat_checker i_chk (
  .ref_clk(ref_clk), .rst_b(rst_b), .hreadyout(hreadyout), .hresp(hresp),
  .seg_load(seg_load), .seg_load_done(seg_load_done), .xlat_valid(xlat_valid),
  .xlat_ready(xlat_ready), .xlat_sensitive(xlat_sensitive), .xlat_done(xlat_done),
  .fault_valid(fault_valid), .fault_code(fault_code), .intr_entry(intr_entry), .emul_mode(emul_mode)
);

// ==== testbench/spat_mem_model.sv ====
// Purpose: table memory seen by the translator
// Assumes: request held until acknowledged
// Notes:   answers LAT+1 cycles after a request is first seen; read data inverts every cycle with no request or ack, holds while counting
`timescale 1ns/1ns
module spat_mem_model #(
  parameter LAT = 2
) (
  input  wire        ref_clk,
  input  wire        rst_b,
  input  wire        mem_req,
  input  wire [31:0] mem_addr,
  output reg         mem_ack = 1'b0,
  output reg  [31:0] mem_rdata = 32'h0
);
  reg [31:0] mem [0:255];
  integer    cnt = 0;
  always @(posedge ref_clk) begin
    if (!rst_b || !mem_req || mem_ack) begin
      cnt       <= 0;
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end else if (cnt == LAT) begin
      mem_ack   <= 1'b1;
      mem_rdata <= mem[mem_addr[9:2]];
    end else
      cnt <= cnt + 1;
  end
endmodule

// ==== testbench/tb_top.sv ====
// Purpose: self-checking bench of the address translator
// Assumes: AHB-Lite zero wait slave, one request at a time
// Notes:   descriptor and page tables are preloaded into the memory model
`timescale 1ns/1ns
`include "spat_map.vh"
module tb_top;
  reg         ref_clk = 1'b0, rst_b = 1'b0, hwrite = 1'b0, seg_load = 1'b0;
  reg  [31:0] haddr = 32'h0, hwdata = 32'h0, xlat_offset = 32'h0, q;
  reg  [1:0]  htrans = 2'h0, seg_load_idx = 2'h0, xlat_seg = 2'h0, xlat_len = 2'h0;
  reg  [15:0] seg_load_sel = 16'h0;
  reg         xlat_valid = 1'b0, xlat_op32 = 1'b0, xlat_sensitive = 1'b0, intr_entry = 1'b0;
  wire        mem_req, mem_ack;
  wire [31:0] mem_addr, mem_rdata;
  reg  [2:0]  f;
  wire        hreadyout, hresp, seg_load_done, xlat_ready, xlat_done, fault_valid, emul_mode;
  wire [31:0] hrdata, phys_addr;
  wire [2:0]  fault_code;
  integer     fail_count = 0, n_compared = 0, k;
  always #5 ref_clk = ~ref_clk;
  spat_translator i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .seg_load(seg_load), .seg_load_idx(seg_load_idx), .seg_load_sel(seg_load_sel),
    .seg_load_done(seg_load_done), .xlat_valid(xlat_valid), .xlat_ready(xlat_ready), .xlat_seg(xlat_seg),
    .xlat_offset(xlat_offset), .xlat_op32(xlat_op32), .xlat_len(xlat_len), .xlat_sensitive(xlat_sensitive),
    .xlat_done(xlat_done), .phys_addr(phys_addr), .fault_valid(fault_valid), .fault_code(fault_code),
    .intr_entry(intr_entry), .emul_mode(emul_mode), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  spat_mem_model i_mem (.ref_clk(ref_clk), .rst_b(rst_b), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  ////////////////////////////////////////
  task finish_test;
    begin
      if (fail_count == 0 && n_compared > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [8*10:1] nm, input [31:0] e, input [31:0] g);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("[ERR] %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task guard(input integer n);
    begin
      if (n >= 100) begin
        fail_count = fail_count + 1;
        $display("[ERR] wait exp answer got timeout");
        finish_test;
      end
    end
  endtask
  task ahb(input w, input [31:0] a, input [31:0] d);
    integer n;
    begin
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      n = 0;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1 && n < 100) begin
        @(posedge ref_clk);
        n = n + 1;
      end
      guard(n);
      htrans <= 2'h0;
      hwdata <= d;
      n = 0;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1 && n < 100) begin
        @(posedge ref_clk);
        n = n + 1;
      end
      guard(n);
      q = hrdata;
    end
  endtask
  task seg(input [1:0] i, input [15:0] v);
    integer n;
    begin
      seg_load_idx <= i;
      seg_load_sel <= v;
      seg_load <= 1'b1;
      @(posedge ref_clk);
      seg_load <= 1'b0;
      n = 0;
      while (seg_load_done !== 1'b1 && n < 100) begin
        @(posedge ref_clk);
        n = n + 1;
      end
      guard(n);
    end
  endtask
  task xlat(input [1:0] s, input [31:0] o, input op32, input [1:0] len, input sens);
    integer n;
    begin
      xlat_seg <= s;
      xlat_offset <= o;
      xlat_op32 <= op32;
      xlat_len <= len;
      xlat_sensitive <= sens;
      xlat_valid <= 1'b1;
      n = 0;
      @(posedge ref_clk);
      while (xlat_ready !== 1'b1 && n < 100) begin
        @(posedge ref_clk);
        n = n + 1;
      end
      guard(n);
      xlat_valid <= 1'b0;
      n = 0;
      @(posedge ref_clk);
      while (xlat_done !== 1'b1 && fault_valid !== 1'b1 && n < 100) begin
        @(posedge ref_clk);
        n = n + 1;
      end
      guard(n);
      q = phys_addr;
      f = (fault_valid === 1'b1) ? fault_code : 3'h0;
    end
  endtask
  ////////////////////////////////////////
  initial begin
    i_mem.mem[8'h01] = 32'h0000_1001;
    i_mem.mem[8'h03] = 32'h7654_3001;
    i_mem.mem[8'h04] = 32'h0000_0000;
    i_mem.mem[8'h12] = 32'h0050_0000;
    i_mem.mem[8'h13] = 32'h0000_0001;
    i_mem.mem[8'h22] = 32'h0060_0000;
    i_mem.mem[8'h23] = 32'h0000_0001;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    for (k = 0; k < 9; k = k + 1) begin
      ahb(1'b0, k * 4, 32'h0);
      chk("reg_reset", 32'h0, q);
    end
    ahb(1'b1, `SPAT_OFS_DIR_BASE, 32'hABCD_E000);
    ahb(1'b0, `SPAT_OFS_DIR_BASE, 32'h0);
    chk("dir_base", 32'hABCD_E000, q);
    ahb(1'b1, `SPAT_OFS_FAULT_ADDR, 32'h1111_1111);
    ahb(1'b0, `SPAT_OFS_FAULT_ADDR, 32'h0);
    chk("fault_addr", 32'h0, q);
    seg(2'h0, 16'h1234);
    xlat(2'h0, 32'h0000_0010, 1'b0, 2'h0, 1'b0);
    chk("real_pa", 32'h0001_2350, q);
    seg(2'h1, 16'hFFFF);
    xlat(2'h1, 32'h0000_FFF0, 1'b0, 2'h1, 1'b0);
    chk("real_trunc", 32'h0000_FFE0, q);
    xlat(2'h0, 32'h0000_FFFF, 1'b0, 2'h1, 1'b0);
    chk("wrap", 32'h1, {29'h0, f});
    xlat(2'h0, 32'h0000_0020, 1'b0, 2'h3, 1'b1);
    chk("real_nochk", 32'h0, {29'h0, f});
    ahb(1'b1, `SPAT_OFS_FLAGS, 32'h1);
    ahb(1'b1, `SPAT_OFS_CTRL, 32'h1);
    @(posedge ref_clk);
    chk("emul_on", 32'h1, {31'h0, emul_mode});
    xlat(2'h0, 32'h0000_0010, 1'b0, 2'h0, 1'b0);
    chk("emul_pa", 32'h0001_2350, q);
    xlat(2'h0, 32'h0000_0000, 1'b0, 2'h0, 1'b1);
    chk("sens", 32'h2, {29'h0, f});
    @(posedge ref_clk);
    chk("emul_exit", 32'h0, {31'h0, emul_mode});
    ahb(1'b0, `SPAT_OFS_FLAGS, 32'h0);
    chk("saved_flag", 32'h2, q & 32'h3);
    ahb(1'b1, `SPAT_OFS_FLAGS, 32'h1);
    @(posedge ref_clk);
    intr_entry <= 1'b1;
    @(posedge ref_clk);
    intr_entry <= 1'b0;
    @(posedge ref_clk);
    chk("intr_exit", 32'h0, {31'h0, emul_mode});
    xlat(2'h0, 32'h0010_0000, 1'b1, 2'h3, 1'b0);
    chk("prot_pa32", 32'h0011_2340, q);
    xlat(2'h0, 32'hABCD_0010, 1'b0, 2'h0, 1'b0);
    chk("prot_pa16", 32'h0001_2350, q);
    ahb(1'b1, `SPAT_OFS_GLOBAL_BASE, 32'h0000_0040);
    ahb(1'b1, `SPAT_OFS_LOCAL_BASE, 32'h0000_0080);
    seg(2'h2, 16'h0008);
    xlat(2'h2, 32'h0000_3010, 1'b1, 2'h0, 1'b0);
    chk("desc_gl", 32'h0050_3010, q);
    seg(2'h3, 16'h000C);
    xlat(2'h3, 32'h0000_0010, 1'b1, 2'h0, 1'b0);
    chk("desc_lc", 32'h0060_0010, q);
    ahb(1'b1, `SPAT_OFS_CTRL, 32'h3);
    xlat(2'h2, 32'h0000_3010, 1'b1, 2'h0, 1'b0);
    chk("page_pa", 32'h7654_3010, q);
    xlat(2'h2, 32'h0000_4010, 1'b1, 2'h0, 1'b0);
    chk("page_flt", 32'h4, {29'h0, f});
    ahb(1'b0, `SPAT_OFS_FAULT_ADDR, 32'h0);
    chk("flt_addr", 32'h0050_4010, q);
    finish_test;
  end
endmodule
